// [csw_defs.vh]
// Purpose: constants for the sync, window and emergency-code logic
// Assumes: 100 MHz clock, object dictionary indices used as addresses
// Notes: header only, definitions and nothing else
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH
`define CSW_IDX_SYNC_ID 16'h1005
`define CSW_IDX_CYCLE 16'h1006
`define CSW_IDX_WINDOW 16'h1007
`define CSW_IDX_NAME 16'h1008
`define CSW_SYNC_ID_RST 32'h0000_0080
`define CSW_CYCLE_RST 32'h0000_0000
`define CSW_WINDOW_RST 32'h0000_0000
`define CSW_GEN_BIT 30
`define CSW_ID_MSB 10
`define CSW_ID_HI_KEEP 21'h180000
`define CSW_CLK_MHZ 100
`define CSW_US_CYCLES (`CSW_CLK_MHZ * 1)
`define CSW_CYCLE_UNIT_US 32'd1000
`define CSW_SYNC_LEN 4'h0
`define CSW_EC_GENERIC 16'h1000
`define CSW_EC_CURRENT 16'h2300
`define CSW_EC_VOLTAGE 16'h3100
`define CSW_EC_TEMP 16'h4200
`define CSW_EC_INTERLOCK 16'h5540
`define CSW_EC_WATCHDOG 16'h6010
`define CSW_EC_SOFTWARE 16'h6100
`define CSW_EC_RATED 16'h6320
`define CSW_EC_BALLAST 16'h7113
`define CSW_EC_BLOCKED 16'h7121
`define CSW_EC_REFCORR 16'h7200
`define CSW_EC_SENSOR1 16'h7305
`define CSW_EC_SENSOR2 16'h7306
`define CSW_EC_SENSORN 16'h7307
`define CSW_EC_NVM 16'h7600
`define CSW_EC_BUSMON 16'h8100
`define CSW_EC_GUARD 16'h8130
`define CSW_EC_PDO_LATE 16'h8200
`define CSW_EC_PDO_LEN 16'h8210
`define CSW_EC_PDO_LONG 16'h8220
`define CSW_EC_SYNC_LEN 16'h8240
`define CSW_EC_SLIP 16'h8400
`define CSW_EC_FOLLOW 16'h8611
`define CSW_EC_LIMIT 16'h8612
`define CSW_NFAULT 24
`endif

// [csw_us_timer.v]
// Purpose: microsecond down-counter with reload, used for period and window
// Assumes: one clock, synchronous active-high reset
// Notes: expired pulses one cycle when the count reaches zero
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.vh"
module csw_us_timer #(
  parameter W = 32
) (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [W-1:0] len_us,
  input wire stop,
  output reg running,
  output wire expired
);
  localparam integer PRE_I = `CSW_US_CYCLES - 1;
  localparam [7:0] PRE = PRE_I[7:0];
  reg [7:0] pre_q;
  reg [W-1:0] cnt_q;
  wire tick = (pre_q == 8'h00);
  assign expired = running && tick && (cnt_q == {{(W-1){1'b0}}, 1'b1});
  always @(posedge clk) begin
    if (rst || stop) begin
      running <= 1'b0;
      pre_q <= PRE;
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      running <= (len_us != {W{1'b0}});
      pre_q <= PRE;
      cnt_q <= len_us;
    end else if (running) begin
      pre_q <= tick ? PRE : pre_q - 8'h01;
      if (tick) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        if (expired)
          running <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [csw_emcy_enc.v]
// Purpose: priority encoder from fault sources to emergency code
// Assumes: fault vector ordered as listed below, bit 0 highest priority
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.vh"
module csw_emcy_enc (
  input wire [`CSW_NFAULT-1:0] fault,
  output reg [15:0] code,
  output wire any
);
  integer i;
  reg [15:0] tbl [0:`CSW_NFAULT-1];
  assign any = |fault;
  always @* begin
    tbl[0] = `CSW_EC_WATCHDOG;
    tbl[1] = `CSW_EC_VOLTAGE;
    tbl[2] = `CSW_EC_CURRENT;
    tbl[3] = `CSW_EC_BUSMON;
    tbl[4] = `CSW_EC_GUARD;
    tbl[5] = `CSW_EC_SENSOR1;
    tbl[6] = `CSW_EC_SENSOR2;
    tbl[7] = `CSW_EC_SENSORN;
    tbl[8] = `CSW_EC_LIMIT;
    tbl[9] = `CSW_EC_TEMP;
    tbl[10] = `CSW_EC_FOLLOW;
    tbl[11] = `CSW_EC_NVM;
    tbl[12] = `CSW_EC_BLOCKED;
    tbl[13] = `CSW_EC_PDO_LATE;
    tbl[14] = `CSW_EC_PDO_LEN;
    tbl[15] = `CSW_EC_PDO_LONG;
    tbl[16] = `CSW_EC_RATED;
    tbl[17] = `CSW_EC_SOFTWARE;
    tbl[18] = `CSW_EC_SYNC_LEN;
    tbl[19] = `CSW_EC_SLIP;
    tbl[20] = `CSW_EC_REFCORR;
    tbl[21] = `CSW_EC_BALLAST;
    tbl[22] = `CSW_EC_INTERLOCK;
    tbl[23] = `CSW_EC_GENERIC;
    code = 16'h0000;
    for (i = `CSW_NFAULT - 1; i >= 0; i = i - 1) begin
      if (fault[i])
        code = tbl[i];
    end
  end
endmodule
`default_nettype wire

// [csw_node.v]
// Purpose: sync producer, sync window supervision and emergency reporting
// Assumes: object dictionary access by index, one clock at 100 MHz
// Notes: sensor faults are split into first, second and higher sensors
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.vh"
module csw_node #(
  parameter NAME_WORDS = 4,
  // arbitrary neutral name, four ascii characters per word
  parameter [32*NAME_WORDS-1:0] DEV_NAME = 128'h6d6f_746f_725f_6e6f_6465_0000_0000_0000
) (
  input wire clk,
  input wire rst,

  // object dictionary access
  input wire od_wr,
  input wire od_rd,
  input wire [15:0] od_index,
  input wire [7:0] od_sub,
  input wire [31:0] od_wdata,
  output reg [31:0] od_rdata_q,
  output reg od_ack_q,
  output reg od_err_q,

  // sync and pdo traffic
  input wire reset_comm,
  input wire rx_sync,
  input wire [3:0] rx_sync_len,
  input wire [10:0] rx_id,
  input wire rx_pdo,
  output wire rx_pdo_accept,
  input wire tx_sync_pdo_req,
  output wire tx_sync_pdo_drop,
  output reg sync_tx_q,
  output reg [10:0] sync_tx_id_q,
  output reg window_open_q,

  // interlock, faults and emergency reports
  input wire interlock_ok,
  output wire motor_enable_ok,
  input wire [`CSW_NFAULT-1:0] fault_in,
  input wire [7:0] error_register,
  output reg emcy_tx_q,
  output reg [31:0] emcy_word_q
);
  // fault vector positions driven from inside this block
  localparam integer F_PDO_LATE = 13;
  localparam integer F_SYNC_LEN = 18;
  localparam integer F_INTERLOCK = 22;

  reg [31:0] sync_id_q;
  reg [31:0] cycle_q;
  reg [31:0] window_q;
  reg [31:0] act_id_q;
  reg [31:0] act_cycle_q;
  reg [31:0] act_window_q;
  reg apply_q;
  reg expired_q;
  reg win_evt_q;
  reg [`CSW_NFAULT-1:0] fault_last_q;
  reg [31:0] od_rdata_d;
  reg od_err_d;
  wire prod_exp;
  wire prod_run;
  wire win_exp;
  wire win_run;
  wire [15:0] emcy_code;
  wire emcy_any;
  wire is_master;
  wire own_sync;
  wire sync_seen;
  wire sync_len_bad;
  reg [`CSW_NFAULT-1:0] faults;
  wire [`CSW_NFAULT-1:0] new_faults;
  wire period_ok;
  wire od_req;
  wire prod_load;
  wire sync_rx_match;
  integer n;

  // applied set only moves on restart or reset communication,
  // so a write alone never disturbs a running sync schedule
  always @(posedge clk) begin
    if (rst) begin
      act_id_q <= `CSW_SYNC_ID_RST;
      act_cycle_q <= `CSW_CYCLE_RST;
      act_window_q <= `CSW_WINDOW_RST;
      apply_q <= 1'b1;
    end else begin
      apply_q <= reset_comm;
      if (reset_comm) begin
        act_id_q <= sync_id_q;
        act_cycle_q <= cycle_q;
        act_window_q <= window_q;
      end
    end
  end

  // object dictionary writes
  always @(posedge clk) begin
    if (rst) begin
      sync_id_q <= `CSW_SYNC_ID_RST;
      cycle_q <= `CSW_CYCLE_RST;
      window_q <= `CSW_WINDOW_RST;
    end else if (od_wr && od_sub == 8'h00) begin
      case (od_index)
        `CSW_IDX_SYNC_ID: begin
          // only the flag bits survive above the 11-bit identifier
          sync_id_q <= {od_wdata[31:`CSW_ID_MSB+1] & `CSW_ID_HI_KEEP,
                        od_wdata[`CSW_ID_MSB:0]};
        end
        `CSW_IDX_CYCLE: begin
          // a refused period keeps the old value; the bus sees an error
          if ((od_wdata % `CSW_CYCLE_UNIT_US) == 32'd0)
            cycle_q <= od_wdata;
        end
        `CSW_IDX_WINDOW: window_q <= od_wdata;
        default: ;
      endcase
    end
  end

  assign period_ok = (od_wdata % `CSW_CYCLE_UNIT_US) == 32'd0;
  assign od_req = od_wr || od_rd;

  // read path and access errors; the name cannot be written
  always @* begin
    od_rdata_d = 32'h0000_0000;
    od_err_d = 1'b0;
    case (od_index)
      `CSW_IDX_SYNC_ID: od_rdata_d = sync_id_q;
      `CSW_IDX_CYCLE: begin
        od_rdata_d = cycle_q;
        od_err_d = od_wr && !period_ok;
      end
      `CSW_IDX_WINDOW: od_rdata_d = window_q;
      `CSW_IDX_NAME: begin
        od_err_d = od_wr;
        od_rdata_d = 32'h0000_0000;
        for (n = 0; n < NAME_WORDS; n = n + 1) begin
          if (od_sub == n[7:0])
            od_rdata_d = DEV_NAME[32*(NAME_WORDS-1-n) +: 32];
        end
      end
      default: od_err_d = 1'b1;
    endcase
    // only the name object has subindices beyond zero
    if (od_index != `CSW_IDX_NAME && od_sub != 8'h00)
      od_err_d = 1'b1;
  end

  always @(posedge clk) begin
    if (rst) begin
      od_rdata_q <= 32'h0000_0000;
      od_ack_q <= 1'b0;
      od_err_q <= 1'b0;
    end else begin
      od_ack_q <= od_req;
      od_err_q <= od_req && od_err_d;
      if (od_rd)
        od_rdata_q <= od_rdata_d;
    end
  end

  // master role comes from the applied word, not the written one
  assign is_master = act_id_q[`CSW_GEN_BIT];

  // producer period: restarts on apply, reloads on each sync sent;
  // an idle master timer keeps reloading, so a zero period stays idle
  assign prod_load = apply_q || prod_exp ||
    (is_master && !prod_run);

  csw_us_timer #(.W(32)) u_prod (
    .clk(clk),
    .rst(rst),
    .load(prod_load),
    .len_us(act_cycle_q),
    .stop(!is_master),
    .running(prod_run),
    .expired(prod_exp)
  );

  assign own_sync = is_master && prod_exp;

  always @(posedge clk) begin
    if (rst) begin
      sync_tx_q <= 1'b0;
      sync_tx_id_q <= 11'h000;
    end else begin
      sync_tx_q <= own_sync;
      sync_tx_id_q <= act_id_q[`CSW_ID_MSB:0];
    end
  end

  // a sync from the bus only counts when it carries the applied id
  assign sync_rx_match = rx_sync && rx_id == act_id_q[`CSW_ID_MSB:0];
  assign sync_seen = own_sync || sync_rx_match;
  // a sync of the wrong length still restarts the window, it is reported
  assign sync_len_bad = sync_rx_match &&
    rx_sync_len != `CSW_SYNC_LEN;

  // window timer; zero length never runs
  csw_us_timer #(.W(32)) u_win (
    .clk(clk),
    .rst(rst),
    .load(sync_seen),
    .len_us(act_window_q),
    .stop(apply_q),
    .running(win_run),
    .expired(win_exp)
  );

  // window_open_q is kept as the inverse of expired_q, both flopped on the same edge
  always @(posedge clk) begin
    if (rst) begin
      expired_q <= 1'b0;
      window_open_q <= 1'b1;
      win_evt_q <= 1'b0;
    end else begin
      win_evt_q <= win_exp;
      if (sync_seen || apply_q) begin
        expired_q <= 1'b0;
        window_open_q <= 1'b1;
      end else if (win_exp && act_window_q != 32'h0) begin
        expired_q <= 1'b1;
        window_open_q <= 1'b0;
      end
    end
  end

  // zero length keeps expired low, so everything passes
  assign tx_sync_pdo_drop = tx_sync_pdo_req && expired_q;
  assign rx_pdo_accept = rx_pdo && !expired_q;
  assign motor_enable_ok = interlock_ok;

  // internal events share the positions of the matching external faults
  always @* begin
    faults = fault_in;
    faults[F_PDO_LATE] = fault_in[F_PDO_LATE] | win_evt_q;
    faults[F_SYNC_LEN] = fault_in[F_SYNC_LEN] | sync_len_bad;
    faults[F_INTERLOCK] = fault_in[F_INTERLOCK] | !interlock_ok;
  end
  assign new_faults = faults & ~fault_last_q;

  csw_emcy_enc u_enc (
    .fault(new_faults),
    .code(emcy_code),
    .any(emcy_any)
  );

  // one emergency per rising fault; same-cycle rises report top one
  always @(posedge clk) begin
    if (rst) begin
      fault_last_q <= {`CSW_NFAULT{1'b0}};
      emcy_tx_q <= 1'b0;
      emcy_word_q <= 32'h0000_0000;
    end else begin
      fault_last_q <= faults;
      emcy_tx_q <= emcy_any;
      if (emcy_any)
        emcy_word_q <= {8'h00, error_register, emcy_code};
    end
  end
endmodule
`default_nettype wire

// [csw_node_checker.sv]
// Purpose: port checks for the sync, window and emergency node
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every node instance
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.vh"
module csw_node_checker (
  input wire clk,
  input wire rst,
  input wire od_wr,
  input wire [15:0] od_index,
  input wire od_ack_q,
  input wire od_err_q,
  input wire rx_pdo,
  input wire rx_pdo_accept,
  input wire tx_sync_pdo_req,
  input wire tx_sync_pdo_drop,
  input wire sync_tx_q,
  input wire window_open_q,
  input wire interlock_ok,
  input wire motor_enable_ok,
  input wire [`CSW_NFAULT-1:0] fault_in,
  input wire [7:0] error_register,
  input wire emcy_tx_q,
  input wire [31:0] emcy_word_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_ACCEPT:
    assert property (rx_pdo_accept == (rx_pdo && window_open_q))
    else $error("pdo acceptance does not follow the window");
  AST_DROP:
    assert property (tx_sync_pdo_drop == (tx_sync_pdo_req && !window_open_q))
    else $error("pdo drop does not follow the window");
  AST_MOTOR:
    assert property (!interlock_ok |-> !motor_enable_ok)
    else $error("motor allowed with interlock cleared");
  AST_LOCK_EMCY:
    assert property ($fell(interlock_ok) |-> ##[1:3]
      (emcy_tx_q && emcy_word_q[15:0] == 16'h5540))
    else $error("no interlock emergency");
  AST_WATCHDOG:
    assert property ($rose(fault_in[0]) |-> ##[1:3]
      (emcy_tx_q && emcy_word_q[15:0] == 16'h6010))
    else $error("no watchdog emergency");
  AST_CLASS:
    assert property (emcy_tx_q |-> emcy_word_q[31:24] == 8'h00 &&
      (emcy_word_q[23:16] == error_register ||
      emcy_word_q[23:16] == $past(error_register)))
    else $error("emergency class byte wrong");
  AST_SYNC_PULSE:
    assert property (sync_tx_q |=> !sync_tx_q)
    else $error("sync pulse too long");
  AST_NAME_RO:
    assert property (od_wr && od_index == `CSW_IDX_NAME |=>
      od_ack_q && od_err_q)
    else $error("name write not refused");
  cover property (sync_tx_q);
  cover property (tx_sync_pdo_drop);
  cover property (emcy_tx_q);
endmodule
bind csw_node csw_node_checker i_chk (.clk, .rst, .od_wr, .od_index,
  .od_ack_q, .od_err_q, .rx_pdo, .rx_pdo_accept, .tx_sync_pdo_req,
  .tx_sync_pdo_drop, .sync_tx_q, .window_open_q, .interlock_ok,
  .motor_enable_ok,
  .fault_in, .error_register, .emcy_tx_q, .emcy_word_q);
`default_nettype wire

// [csw_net_model.sv]
// Purpose: far-side network node sending sync frames
// Assumes: send is high one cycle per frame
// Notes: idle fields carry the inverse so they never look valid
`timescale 1ns/1ns
`default_nettype none
module csw_net_model (
  input wire send,
  input wire [3:0] len,
  input wire [10:0] id,
  output wire rx_sync,
  output wire [3:0] rx_sync_len,
  output wire [10:0] rx_id
);
  assign rx_sync = send;
  assign rx_sync_len = send ? len : ~len;
  assign rx_id = send ? id : ~id;
endmodule
`default_nettype wire

// [test_csw_node.sv]
// Purpose: self-checking bench for the sync, window and emergency node
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: the master run waits one whole 1 ms sync period
`timescale 1ns/1ns
`default_nettype none
module test_csw_node;
  // arbitrary neutral name
  localparam [127:0] NAME = 128'h7465_7374_5f6e_6f64_6500_0000_0000_0000;
  localparam [383:0] EC = {16'h1000, 16'h5540, 16'h7113, 16'h7200,
    16'h8400, 16'h8240, 16'h6100, 16'h6320, 16'h8220, 16'h8210,
    16'h8200, 16'h7121, 16'h7600, 16'h8611, 16'h4200, 16'h8612,
    16'h7307, 16'h7306, 16'h7305, 16'h8130, 16'h8100, 16'h2300,
    16'h3100, 16'h6010};
  reg clk = 1'h0, rst = 1'h1, od_wr = 1'h0, od_rd = 1'h0, send = 1'h0;
  reg reset_comm = 1'h0, rx_pdo = 1'h0, tx_sync_pdo_req = 1'h0;
  reg interlock_ok = 1'h1;
  reg [15:0] od_index = 16'h0;
  reg [7:0] od_sub = 8'h0, error_register = 8'h0;
  reg [31:0] od_wdata = 32'h0, rd;
  reg [3:0] len = 4'h0;
  reg [10:0] id = 11'h080;
  reg [23:0] fault_in = 24'h0;
  wire [31:0] od_rdata_q, emcy_word_q;
  wire [10:0] sync_tx_id_q, rx_id;
  wire [3:0] rx_sync_len;
  wire od_ack_q, od_err_q, rx_pdo_accept, tx_sync_pdo_drop, sync_tx_q;
  wire window_open_q, motor_enable_ok, emcy_tx_q, rx_sync;
  integer miscompares = 0, cmp_count = 0, i, n;
  csw_node #(.DEV_NAME(NAME)) i_dut (.clk, .rst, .od_wr, .od_rd,
    .od_index, .od_sub, .od_wdata, .od_rdata_q, .od_ack_q, .od_err_q,
    .reset_comm, .rx_sync, .rx_sync_len, .rx_id, .rx_pdo, .rx_pdo_accept,
    .tx_sync_pdo_req, .tx_sync_pdo_drop, .sync_tx_q, .sync_tx_id_q,
    .window_open_q, .interlock_ok, .motor_enable_ok, .fault_in,
    .error_register, .emcy_tx_q, .emcy_word_q);
  csw_net_model i_net (.send, .len, .id, .rx_sync, .rx_sync_len, .rx_id);
  initial forever #5 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  function sig(input [1:0] s);
    sig = s == 2'h0 ? od_ack_q : s == 2'h1 ? emcy_tx_q :
      s == 2'h2 ? window_open_q : sync_tx_q;
  endfunction
  // n returns the cycles waited, used for timing checks
  task wait_for(input [1:0] s, input v, input integer lim);
    begin
      n = 0;
      #1;
      while (sig(s) !== v && n < lim) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (sig(s) !== v) begin
        chk(n, 0);
        wrap_up;
      end
    end
  endtask
  task od(input w, input [15:0] x, input [7:0] s, input [31:0] d,
      input e);
    begin
      @(posedge clk);
      od_wr <= w;
      od_rd <= !w;
      od_index <= x;
      od_sub <= s;
      od_wdata <= d;
      @(posedge clk);
      od_wr <= 1'h0;
      od_rd <= 1'h0;
      wait_for(2'h0, 1'h1, 4);
      chk(od_err_q, e);
      rd = od_rdata_q;
    end
  endtask
  task frame(input [3:0] l, input [10:0] d);
    begin
      @(posedge clk);
      len <= l;
      id <= d;
      send <= 1'h1;
      @(posedge clk);
      send <= 1'h0;
    end
  endtask
  task emcy(input [15:0] c);
    begin
      wait_for(2'h1, 1'h1, 6);
      chk(emcy_word_q, {8'h0, error_register, c});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    #1 chk({window_open_q, od_ack_q, emcy_tx_q, sync_tx_q}, 4'h8);
    od(1'h0, 16'h1005, 8'h0, 32'h0, 1'h0);
    chk(rd, 32'h80);
    od(1'h0, 16'h1006, 8'h0, 32'h0, 1'h0);
    chk(rd, 32'h0);
    od(1'h1, 16'h1006, 8'h0, 32'h5dc, 1'h1);
    od(1'h0, 16'h1006, 8'h0, 32'h0, 1'h0);
    chk(rd, 32'h0);
    od(1'h0, 16'h1005, 8'h1, 32'h0, 1'h1);
    od(1'h1, 16'h1008, 8'h0, 32'h0, 1'h1);
    od(1'h0, 16'h1009, 8'h0, 32'h0, 1'h1);
    od(1'h0, 16'h1008, 8'h1, 32'h0, 1'h0);
    chk(rd, NAME[95:64]);
    od(1'h1, 16'h1005, 8'h0, 32'h2000_1881, 1'h0);
    od(1'h0, 16'h1005, 8'h0, 32'h0, 1'h0);
    chk(rd, 32'h81);
    frame(4'h0, 11'h080);
    rx_pdo <= 1'h1;
    tx_sync_pdo_req <= 1'h1;
    repeat (600) @(posedge clk);
    #1 chk({window_open_q, rx_pdo_accept, tx_sync_pdo_drop}, 3'h6);
    $display("registers and open window done");
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge clk);
      error_register <= i[7:0] ^ 8'h3c;
      fault_in <= 24'h1 << i;
      emcy(EC[16*i +: 16]);
      @(posedge clk);
      fault_in <= 24'h0;
    end
    @(posedge clk);
    interlock_ok <= 1'h0;
    emcy(16'h5540);
    chk(motor_enable_ok, 1'h0);
    @(posedge clk);
    interlock_ok <= 1'h1;
    frame(4'h3, 11'h080);
    emcy(16'h8240);
    $display("emergency codes done");
    od(1'h1, 16'h1007, 8'h0, 32'h5, 1'h0);
    od(1'h0, 16'h1007, 8'h0, 32'h0, 1'h0);
    chk(rd, 32'h5);
    @(posedge clk);
    reset_comm <= 1'h1;
    @(posedge clk);
    reset_comm <= 1'h0;
    frame(4'h0, 11'h081);
    wait_for(2'h2, 1'h0, 600);
    chk(n > 495 && n < 505, 1'h1);
    emcy(16'h8200);
    chk({tx_sync_pdo_drop, rx_pdo_accept}, 2'h2);
    frame(4'h0, 11'h081);
    wait_for(2'h2, 1'h1, 4);
    chk(rx_pdo_accept, 1'h1);
    wait_for(2'h2, 1'h0, 600);
    $display("window done");
    od(1'h1, 16'h1005, 8'h0, 32'h4000_0082, 1'h0);
    od(1'h1, 16'h1006, 8'h0, 32'h3e8, 1'h0);
    frame(4'h0, 11'h082);
    repeat (3) @(posedge clk);
    #1 chk(window_open_q, 1'h0);
    @(posedge clk);
    reset_comm <= 1'h1;
    @(posedge clk);
    reset_comm <= 1'h0;
    wait_for(2'h3, 1'h1, 100100);
    chk(n > 99990 && n < 100010, 1'h1);
    chk(sync_tx_id_q, 11'h082);
    $display("sync master done");
    wrap_up;
  end
endmodule
`default_nettype wire
